/* File: core/watchdog_pkg.sv */
// constants shared by the watchdog refresh and time-out block
// assumes a single 20 MHz clock domain and an AXI4-Lite register port
//
// What this block does
// - first enable loads counter from reload value
// - each count tick decrements counter toward zero
// - refresh instruction reloads counter, counting resumes
// - debug mode refreshes counter continuously, never times out
// - option bit selects interrupt or reset time-out
// - interrupt time-out requests interrupt, sets time-out flag
// - after interrupt time-out roll to 0x0fffff, keep counting
// - reading reset cause register clears time-out flag
// - stop-mode interrupt time-out starts recovery and interrupts
// - stop-mode interrupt time-out sets time-out and stop flags
package watchdog_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CAUSE = 8'h0c;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CAUSE_TO_BIT = 0;
  localparam int CAUSE_STOP_BIT = 1;
  localparam logic RST_EN = 1'b0;
  localparam logic [23:0] RST_RELOAD = 24'hffffff;
  localparam logic [23:0] RST_COUNT = 24'h000000;

  // ****************************************************************
  // counter values and option encoding
  // ****************************************************************
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_ONE = 24'h000001;
  localparam logic [23:0] CNT_ROLLOVER = 24'h0fffff;
  localparam logic SEL_IRQ = 1'b1;

  // ****************************************************************
  // bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: core/watchdog_refresh_timeout.sv */
// watchdog down-counter with refresh, debug hold-off and time-out response
// assumes refresh, tick, debug and stop inputs are synchronous to mclk
`timescale 1ns/100ps
module watchdog_refresh_timeout
  import watchdog_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic refresh_instr,
  input wire logic count_tick,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic timeout_response_select,
  output logic watchdog_irq,
  output logic sys_reset_req,
  output logic stop_recovery
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic en;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] count;
    logic flag_to;
    logic flag_stop;
    logic awrdy;
    logic [7:0] awaddr;
    logic wrdy;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic rst_req;
    logic smr;
  } timer_state_s;

  // ready flops start high so the first request after reset is taken at once
  localparam timer_state_s STATE_RST = '{
    en: RST_EN,
    reload: RST_RELOAD,
    count: RST_COUNT,
    flag_to: 1'b0,
    flag_stop: 1'b0,
    awrdy: 1'b1,
    awaddr: 8'h00,
    wrdy: 1'b1,
    wdata: 32'h00000000,
    wstrb: 4'h0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arrdy: 1'b1,
    rvalid: 1'b0,
    rdata: 32'h00000000,
    rresp: RESP_OKAY,
    irq: 1'b0,
    rst_req: 1'b0,
    smr: 1'b0
  };

  timer_state_s q;
  timer_state_s d;

  // ****************************************************************
  // address decode and bus words
  // ****************************************************************
  typedef enum logic [2:0] {
    REG_CTRL,
    REG_RELOAD,
    REG_COUNT,
    REG_CAUSE,
    REG_NONE
  } reg_sel_e;

  // one decoder for both channels, so reads and writes cannot disagree on the map
  function automatic reg_sel_e reg_decode(input logic [7:0] addr);
    reg_sel_e sel;
    case (addr)
      OFS_CTRL: sel = REG_CTRL;
      OFS_RELOAD: sel = REG_RELOAD;
      OFS_COUNT: sel = REG_COUNT;
      OFS_CAUSE: sel = REG_CAUSE;
      default: sel = REG_NONE;
    endcase
    return sel;
  endfunction

  // counter-wide values sit in the low bits, upper bits read 0
  function automatic logic [31:0] cnt_word(input logic [CNT_W-1:0] value);
    return {{(32-CNT_W){1'b0}}, value};
  endfunction

  function automatic logic [31:0] ctrl_word(input logic en);
    logic [31:0] word;
    word = 32'h00000000;
    word[CTRL_EN_BIT] = en;
    return word;
  endfunction

  // flags are reported as they stood before the clearing read
  function automatic logic [31:0] cause_word(input logic to_flag, input logic stop_flag);
    logic [31:0] word;
    word = 32'h00000000;
    word[CAUSE_TO_BIT] = to_flag;
    word[CAUSE_STOP_BIT] = stop_flag;
    return word;
  endfunction

  // merge write data into an old word under the byte strobes
  function automatic logic [31:0] wr_merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [31:0] merged;
    logic en_rise;
    logic rd_clear;
    logic to_evt;
    reg_sel_e wsel;
    reg_sel_e rsel;
    logic irq_mode;
    merged = 32'h00000000;
    en_rise = 1'b0;
    rd_clear = 1'b0;
    to_evt = 1'b0;
    wsel = reg_decode(q.awaddr);
    rsel = reg_decode(s_axi_araddr);
    irq_mode = (timeout_response_select == SEL_IRQ);
    d = q;
    d.irq = 1'b0;
    d.rst_req = 1'b0;
    d.smr = 1'b0;

    // ****************************************************************
    // write channel
    // ****************************************************************
    // address and data are latched independently, either may come first
    if (q.awrdy && s_axi_awvalid) begin
      d.awrdy = 1'b0;
      d.awaddr = s_axi_awaddr;
    end
    if (q.wrdy && s_axi_wvalid) begin
      d.wrdy = 1'b0;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end

    // both halves held: perform the write and raise the response
    if (!q.awrdy && !q.wrdy && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (wsel)
        REG_CTRL: begin
          merged = wr_merge(ctrl_word(q.en), q.wdata, q.wstrb);
          d.en = merged[CTRL_EN_BIT];
          en_rise = merged[CTRL_EN_BIT] & ~q.en;
        end
        REG_RELOAD: begin
          merged = wr_merge(cnt_word(q.reload), q.wdata, q.wstrb);
          d.reload = merged[CNT_W-1:0];
        end
        REG_COUNT, REG_CAUSE: begin
          // read-only, write accepted and dropped
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awrdy = 1'b1;
      d.wrdy = 1'b1;
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    // read answers one cycle after the address is taken
    if (q.arrdy && s_axi_arvalid) begin
      d.arrdy = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h00000000;
      case (rsel)
        REG_CTRL: d.rdata = ctrl_word(q.en);
        REG_RELOAD: d.rdata = cnt_word(q.reload);
        REG_COUNT: d.rdata = cnt_word(q.count);
        REG_CAUSE: begin
          d.rdata = cause_word(q.flag_to, q.flag_stop);
          rd_clear = 1'b1;
        end
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arrdy = 1'b1;
    end

    // ****************************************************************
    // counter
    // ****************************************************************
    if (rd_clear) begin
      d.flag_to = 1'b0;
      d.flag_stop = 1'b0;
    end
    // a reload of zero holds under reset response and fires only after the rollover under interrupt response: only the step from one to zero fires
    // clearing the enable freezes the count; setting it again reloads
    if (en_rise) begin
      d.count = q.reload;
    end else if (q.en && (debug_mode || refresh_instr)) begin
      // debug keeps reloading, so a time-out cannot happen under the debugger
      d.count = q.reload;
    end else if (q.en && count_tick) begin
      if (q.count == CNT_ZERO) begin
        // reset response holds at zero; the system reset is expected to follow
        if (irq_mode) begin
          d.count = CNT_ROLLOVER;
        end
      end else begin
        d.count = q.count - CNT_ONE;
        to_evt = (q.count == CNT_ONE);
      end
    end

    // ****************************************************************
    // time-out response
    // ****************************************************************
    // flags are set after the read clear so a coincident event survives
    if (to_evt) begin
      if (irq_mode) begin
        d.irq = 1'b1;
        d.flag_to = 1'b1;
        if (stop_mode) begin
          d.smr = 1'b1;
          d.flag_stop = 1'b1;
        end
      end else begin
        d.rst_req = 1'b1;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awrdy;
  assign s_axi_wready = q.wrdy;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign watchdog_irq = q.irq;
  assign sys_reset_req = q.rst_req;
  assign stop_recovery = q.smr;

endmodule

/* File: tb/cpu_intc_model.sv */
// cpu and interrupt controller stand-in
// assumes bench requests arrive one cycle ahead of the pins
`timescale 1ns/100ps
module cpu_intc_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick_en,
  input wire logic do_ref,
  input wire logic clr,
  input wire logic watchdog_irq,
  output logic count_tick,
  output logic refresh_instr,
  output logic pend
);
  // ****
  // pins and pending latch
  // ****
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_tick <= 1'b0;
      refresh_instr <= 1'b0;
      pend <= 1'b0;
    end else begin
      count_tick <= tick_en;
      refresh_instr <= do_ref;
      // a new request wins over a clear in the same cycle
      pend <= watchdog_irq | (pend & ~clr);
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the watchdog block
// assumes the checker binds itself from its own file
`timescale 1ns/100ps
module tb_top;
  import watchdog_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, tick_en = 1'b0, do_ref = 1'b0, clr = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, debug_mode = 1'b0, stop_mode = 1'b0;
  logic timeout_response_select = 1'b1, pend;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic count_tick, refresh_instr, watchdog_irq, sys_reset_req, stop_recovery;
  int n_fail = 0, num_checks = 0, n_irq = 0, n_rst = 0, n_rec = 0;
  always #25 mclk = ~mclk;
  watchdog_refresh_timeout dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .refresh_instr, .count_tick,
    .debug_mode, .stop_mode, .timeout_response_select, .watchdog_irq, .sys_reset_req,
    .stop_recovery);
  cpu_intc_model partner (.mclk, .rst_n, .tick_en, .do_ref, .clr, .watchdog_irq,
    .count_tick, .refresh_instr, .pend);
  always @(posedge mclk) begin
    n_irq <= n_irq + (watchdog_irq === 1'b1);
    n_rst <= n_rst + (sys_reset_req === 1'b1);
    n_rec <= n_rec + (stop_recovery === 1'b1);
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    last_resp = s_axi_bresp;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    last_resp = s_axi_rresp;
    chk(s_axi_rdata, e);
    @(posedge mclk);
  endtask
  task automatic ticks(input int n);
    tick_en <= 1'b1;
    repeat (n) @(posedge mclk);
    tick_en <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rd(OFS_RELOAD, 32'h00ffffff);
    rd(8'h10, 32'h0);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    wr(8'h12, 32'h00000001);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    rd(OFS_CTRL, 32'h0);
    wr(OFS_RELOAD, 32'hff000003);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rd(OFS_RELOAD, 32'h3);
  endtask
  task automatic t_count;
    wr(OFS_CTRL, 32'h1);
    rd(OFS_COUNT, 32'h3);
    wr(OFS_COUNT, 32'h00000005);
    ticks(2);
    rd(OFS_COUNT, 32'h1);
    do_ref <= 1'b1;
    @(posedge mclk);
    do_ref <= 1'b0;
    // the reload lands one edge after the model raises its pin
    @(posedge mclk);
    rd(OFS_COUNT, 32'h3);
  endtask
  task automatic t_irq;
    stop_mode <= 1'b1;
    ticks(3);
    chk(32'(n_irq), 32'h1);
    chk(32'(n_rec), 32'h1);
    chk(32'(pend), 32'h1);
    rd(OFS_CAUSE, 32'h3);
    rd(OFS_CAUSE, 32'h0);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    stop_mode <= 1'b0;
    ticks(1);
    chk(32'(pend), 32'h0);
    rd(OFS_COUNT, 32'h000fffff);
  endtask
  task automatic t_modes;
    debug_mode <= 1'b1;
    ticks(4);
    rd(OFS_COUNT, 32'h3);
    debug_mode <= 1'b0;
    timeout_response_select <= 1'b0;
    ticks(3);
    chk(32'(n_rst), 32'h1);
    chk(32'(n_irq), 32'h1);
    ticks(2);
    rd(OFS_COUNT, 32'h0);
  endtask
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_count();
    t_irq();
    t_modes();
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
endmodule

/* File: tb/watchdog_checker.sv */
// timing checks on the watchdog time-out pins
// assumes binding into watchdog_refresh_timeout
`timescale 1ns/100ps
module watchdog_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic count_tick,
  input wire logic refresh_instr,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic timeout_response_select,
  input wire logic watchdog_irq,
  input wire logic sys_reset_req,
  input wire logic stop_recovery
);
  // ****
  // time-out events
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_NO_TICK: assert property (!$past(count_tick) |-> !watchdog_irq && !sys_reset_req)
    else $error("event without tick");
  AST_REFRESH: assert property ($past(refresh_instr) |-> !watchdog_irq && !sys_reset_req)
    else $error("event after refresh");
  AST_DEBUG: assert property ($past(debug_mode) |-> !watchdog_irq && !sys_reset_req)
    else $error("event in debug");
  AST_SEL_IRQ: assert property (watchdog_irq |-> $past(timeout_response_select))
    else $error("irq in reset mode");
  AST_SEL_RST: assert property (sys_reset_req |-> !$past(timeout_response_select))
    else $error("reset in irq mode");
  AST_RST_PULSE: assert property (sys_reset_req |=> !sys_reset_req && !watchdog_irq)
    else $error("reset pulse too long");
  AST_STOP_PAIR: assert property (stop_recovery |-> watchdog_irq && $past(stop_mode))
    else $error("recovery without irq");
  AST_STOP_SET: assert property (watchdog_irq && $past(stop_mode) |-> stop_recovery)
    else $error("irq in stop lacks recovery");
  cover property (watchdog_irq);
  cover property (sys_reset_req);
  cover property (stop_recovery);
endmodule

bind watchdog_refresh_timeout watchdog_checker chk_i (.mclk, .rst_n, .count_tick,
  .refresh_instr, .debug_mode, .stop_mode, .timeout_response_select, .watchdog_irq,
  .sys_reset_req, .stop_recovery);
